// [isafid_pkg.sv]
// Constants for the instruction-set feature identification register.
// Assumes a single 64-bit read-only register reached by system-register read.
package isafid_pkg;
    localparam int          REG_W          = 64;
    localparam int          LO_W           = 36;
    localparam int          FLD_W          = 4;
    // Field positions (low bit)
    localparam int          HASH3_LSB      = 32;
    localparam int          RDMAC_LSB      = 28;
    localparam int          TMEM_LSB       = 24;
    localparam int          ATOM_LSB       = 20;
    localparam int          CRC_LSB        = 16;
    localparam int          SHA2_LSB       = 12;
    localparam int          SHA1_LSB       = 8;
    localparam int          AES_LSB        = 4;
    localparam int          RSV_LSB        = 0;
    // Field codes
    localparam logic [3:0]  HASH3_ON       = 4'h1;
    localparam logic [3:0]  RDMAC_CODE     = 4'h1;
    localparam logic [3:0]  TMEM_CODE      = 4'h0;
    localparam logic [3:0]  ATOM_CODE      = 4'h2;
    localparam logic [3:0]  CRC_CODE       = 4'h1;
    localparam logic [3:0]  SHA2_ON        = 4'h2;
    localparam logic [3:0]  SHA1_ON        = 4'h1;
    localparam logic [3:0]  AES_ON         = 4'h2;
    localparam logic [3:0]  FLD_OFF        = 4'h0;
    // Encoding of the register
    localparam logic [1:0]  ENC_OP0        = 2'h3;
    localparam logic [2:0]  ENC_OP1        = 3'h0;
    localparam logic [3:0]  ENC_CRN        = 4'h0;
    localparam logic [3:0]  ENC_CRM        = 4'h6;
    localparam logic [2:0]  ENC_OP2        = 3'h0;
    // Trap syndrome class and privilege levels
    localparam logic [5:0]  TRAP_CLASS     = 6'h18;
    localparam logic [1:0]  USER_LEVEL     = 2'h0;
    localparam logic [1:0]  KERNEL_LEVEL   = 2'h1;
    localparam logic [1:0]  HYP_LEVEL      = 2'h2;
    localparam logic [1:0]  MONITOR_LEVEL  = 2'h3;
    localparam logic [63:0] RESET_VAL      = 64'h0;

    typedef enum logic [1:0] {
        ISAFID_IDLE,
        ISAFID_DONE
    } isafid_phase_t;
endpackage

// [isafid_top.sv]
// Feature identification register, lower fields, with read access checks.
// Assumes the pipeline presents one read request per cycle, synchronous to clk.
`timescale 1ns/1ns

module isafid_top
    import isafid_pkg::*;
#(
    parameter bit cipher_option_param = 1'b1
) (
    input  wire logic                   clk,
    input  wire logic                   rstn,
    input  wire logic                   ce,
    input  wire logic                   cipher_option_off_in,
    input  wire logic                   rd_req,
    input  wire logic [1:0]             rd_op0,
    input  wire logic [2:0]             rd_op1,
    input  wire logic [3:0]             rd_crn,
    input  wire logic [3:0]             rd_crm,
    input  wire logic [2:0]             rd_op2,
    input  wire logic [1:0]             current_priv_level,
    input  wire logic                   hyp_level_active,
    input  wire logic                   hyp_trap_general_ctl,
    input  wire logic                   hyp_trap_id_group3_ctl,
    output logic                        rd_valid,
    output logic [isafid_pkg::REG_W-1:0] rd_data,
    output logic                        trap_valid,
    output logic [1:0]                  trap_level,
    output logic [5:0]                  trap_class,
    output logic                        sel_miss
);
    import isafid_pkg::*;

    typedef struct packed {
        logic          strap_done;
        logic          cipher_on;
        logic          rd_valid;
        logic [63:0]   rd_data;
        logic          trap_valid;
        logic [1:0]    trap_level;
        logic [5:0]    trap_class;
        logic          sel_miss;
    } isafid_state_t;

    isafid_state_t st_q;
    isafid_state_t st_d;

    // Decode shared by the read path and the assertions
    function automatic logic is_this_reg(input logic [1:0] op0, input logic [2:0] op1,
                                         input logic [3:0] crn, input logic [3:0] crm,
                                         input logic [2:0] op2);
        is_this_reg = (op0 == ENC_OP0) && (op1 == ENC_OP1) && (crn == ENC_CRN)
                      && (crm == ENC_CRM) && (op2 == ENC_OP2);
    endfunction

    function automatic logic [63:0] feature_word(input logic on);
        logic [63:0] w;
        w = RESET_VAL;
        // Upper fields belong to another block and read zero here
        w[HASH3_LSB +: FLD_W] = on ? HASH3_ON : FLD_OFF;
        w[RDMAC_LSB +: FLD_W] = RDMAC_CODE;
        w[TMEM_LSB  +: FLD_W] = TMEM_CODE;
        w[ATOM_LSB  +: FLD_W] = ATOM_CODE;
        w[CRC_LSB   +: FLD_W] = CRC_CODE;
        w[SHA2_LSB  +: FLD_W] = on ? SHA2_ON : FLD_OFF;
        w[SHA1_LSB  +: FLD_W] = on ? SHA1_ON : FLD_OFF;
        w[AES_LSB   +: FLD_W] = on ? AES_ON : FLD_OFF;
        w[RSV_LSB   +: FLD_W] = FLD_OFF;
        feature_word = w;
    endfunction

    logic hit;
    assign hit = rd_req && is_this_reg(rd_op0, rd_op1, rd_crn, rd_crm, rd_op2);

    always_comb begin
        st_d            = st_q;
        st_d.rd_valid   = 1'b0;
        st_d.trap_valid = 1'b0;
        st_d.sel_miss   = 1'b0;
        st_d.rd_data    = RESET_VAL;
        st_d.trap_level = USER_LEVEL;
        st_d.trap_class = 6'h00;
        // Disable input caught once, on the first enabled edge after release
        if (!st_q.strap_done) begin
            st_d.strap_done = 1'b1;
            st_d.cipher_on  = cipher_option_param && !cipher_option_off_in;
        end else if (rd_req && !hit) begin
            // Other encodings are decoded elsewhere; flag them only
            st_d.sel_miss = 1'b1;
        end else if (hit) begin
            case (current_priv_level)
                USER_LEVEL: begin
                    st_d.trap_valid = 1'b1;
                    st_d.trap_class = TRAP_CLASS;
                    st_d.trap_level = (hyp_level_active && hyp_trap_general_ctl) ? HYP_LEVEL : KERNEL_LEVEL;
                end
                KERNEL_LEVEL: begin
                    if (hyp_level_active && hyp_trap_id_group3_ctl) begin
                        st_d.trap_valid = 1'b1;
                        st_d.trap_class = TRAP_CLASS;
                        st_d.trap_level = HYP_LEVEL;
                    end else begin
                        st_d.rd_valid = 1'b1;
                        st_d.rd_data  = feature_word(st_q.cipher_on);
                    end
                end
                default: begin
                    st_d.rd_valid = 1'b1;
                    st_d.rd_data  = feature_word(st_q.cipher_on);
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign rd_valid   = st_q.rd_valid;
    assign rd_data    = st_q.rd_data;
    assign trap_valid = st_q.trap_valid;
    assign trap_level = st_q.trap_level;
    assign trap_class = st_q.trap_class;
    assign sel_miss   = st_q.sel_miss;

    sequence s_hit_at(logic [1:0] lvl);
        ce && st_q.strap_done && hit && current_priv_level == lvl;
    endsequence

    a_user_read_traps: assert property (@(posedge clk) disable iff (!rstn)
        s_hit_at(USER_LEVEL) |=> trap_valid && !rd_valid && trap_class == 6'h18
            && trap_level == ((($past(hyp_level_active) && $past(hyp_trap_general_ctl))) ? 2'h2 : 2'h1))
        else $error("user read did not trap correctly");
    a_kernel_id3_trap: assert property (@(posedge clk) disable iff (!rstn)
        s_hit_at(KERNEL_LEVEL) |=> (trap_valid == ($past(hyp_level_active) && $past(hyp_trap_id_group3_ctl)))
            && (rd_valid != trap_valid))
        else $error("kernel read trap decision wrong");
    a_high_levels_read: assert property (@(posedge clk) disable iff (!rstn)
        (s_hit_at(HYP_LEVEL) or s_hit_at(MONITOR_LEVEL)) |=> rd_valid && !trap_valid)
        else $error("privileged read did not return value");
    a_fixed_fields_ok: assert property (@(posedge clk) disable iff (!rstn)
        rd_valid |-> rd_data[31:16] == 16'h1021)
        else $error("fixed feature fields wrong");
    a_cipher_fields_ok: assert property (@(posedge clk) disable iff (!rstn)
        rd_valid && st_q.cipher_on |-> rd_data[35:32] == 4'h1 && rd_data[15:4] == 12'h212)
        else $error("cipher fields wrong when enabled");
    a_cipher_off_zero: assert property (@(posedge clk) disable iff (!rstn)
        rd_valid && !st_q.cipher_on |-> rd_data[35:32] == 4'h0 && rd_data[15:4] == 12'h000)
        else $error("cipher fields not zero when disabled");
    a_strap_sample: assert property (@(posedge clk) disable iff (!rstn)
        ce && !st_q.strap_done ##1 st_q.strap_done |-> st_q.cipher_on
            == (cipher_option_param && !$past(cipher_option_off_in)))
        else $error("cipher strap sampled wrongly");
    a_strap_stable: assert property (@(posedge clk) disable iff (!rstn)
        st_q.strap_done |=> $stable(st_q.cipher_on))
        else $error("cipher state changed after reset");
    a_reserved_zero: assert property (@(posedge clk) disable iff (!rstn)
        rd_valid |-> rd_data[3:0] == 4'h0 && rd_data[63:36] == 28'h0)
        else $error("reserved bits not zero");
    a_decode_only: assert property (@(posedge clk) disable iff (!rstn)
        ce && st_q.strap_done && rd_req && !is_this_reg(rd_op0, rd_op1, rd_crn, rd_crm, rd_op2)
            |=> sel_miss && !rd_valid && !trap_valid)
        else $error("foreign encoding answered");

    // Request shapes that pick the trap target
    sequence s_user_to_hyp;
        s_hit_at(USER_LEVEL) ##0 (hyp_level_active && hyp_trap_general_ctl);
    endsequence

    sequence s_user_to_kern;
        s_hit_at(USER_LEVEL) ##0 !(hyp_level_active && hyp_trap_general_ctl);
    endsequence

    sequence s_kern_to_hyp;
        s_hit_at(KERNEL_LEVEL) ##0 (hyp_level_active && hyp_trap_id_group3_ctl);
    endsequence

    sequence s_kern_clear;
        s_hit_at(KERNEL_LEVEL) ##0 !(hyp_level_active && hyp_trap_id_group3_ctl);
    endsequence

    // Data bus idles at zero so a stray sample never looks like a feature
    a_rd_data_idle: assert property (@(posedge clk) disable iff (!rstn)
        !rd_valid |-> rd_data == RESET_VAL)
        else $error("read data not zero while idle");

    // Trap fields only meaningful with their strobe
    a_trap_fields_idle: assert property (@(posedge clk) disable iff (!rstn)
        !trap_valid |-> trap_class == 6'h00 && trap_level == USER_LEVEL)
        else $error("trap fields not zero while idle");

    // One request gives one kind of answer
    a_single_answer: assert property (@(posedge clk) disable iff (!rstn)
        $onehot0({rd_valid, trap_valid, sel_miss}))
        else $error("more than one answer at once");

    // Clock enable low freezes everything, outputs included
    a_freeze_state: assert property (@(posedge clk) disable iff (!rstn)
        !ce |=> $stable(st_q))
        else $error("state moved with clock enable low");

    // Requests on the strap edge are dropped silently
    a_strap_quiet: assert property (@(posedge clk) disable iff (!rstn)
        ce && !st_q.strap_done |=> !rd_valid && !trap_valid && !sel_miss)
        else $error("answer on strap edge");

    // No request, no answer
    a_idle_quiet: assert property (@(posedge clk) disable iff (!rstn)
        ce && st_q.strap_done && !rd_req |=> !rd_valid && !trap_valid && !sel_miss)
        else $error("answer without request");

    // Kernel read with the id-group-3 trap off returns data
    a_kernel_data_ok: assert property (@(posedge clk) disable iff (!rstn)
        s_kern_clear |=> rd_valid && !trap_valid)
        else $error("kernel read did not return value");

    // Kernel read with the id-group-3 trap on goes to the hypervisor
    a_kernel_hyp_dest: assert property (@(posedge clk) disable iff (!rstn)
        s_kern_to_hyp |=> trap_valid && trap_level == HYP_LEVEL && trap_class == TRAP_CLASS)
        else $error("kernel trap target wrong");

    // User read with the general trap on goes to the hypervisor
    a_user_hyp_dest: assert property (@(posedge clk) disable iff (!rstn)
        s_user_to_hyp |=> trap_valid && trap_level == HYP_LEVEL)
        else $error("user trap not sent to hypervisor");

    // Otherwise the user read lands at the kernel
    a_user_kern_dest: assert property (@(posedge clk) disable iff (!rstn)
        s_user_to_kern |=> trap_valid && trap_level == KERNEL_LEVEL)
        else $error("user trap not sent to kernel");

    // A build without the option can never report it
    a_off_build_zero: assert property (@(posedge clk) disable iff (!rstn)
        !cipher_option_param |-> !st_q.cipher_on)
        else $error("cipher reported in build without option");

    // Disable strap high at the sampling edge keeps the option off
    a_off_in_blocks: assert property (@(posedge clk) disable iff (!rstn)
        ce && !st_q.strap_done && cipher_option_off_in |=> !st_q.cipher_on)
        else $error("disable strap ignored");

    // A trapped read must not leak the value
    a_trap_no_data: assert property (@(posedge clk) disable iff (!rstn)
        trap_valid |-> rd_data == RESET_VAL)
        else $error("trapped read leaked data");

    // Foreign encodings only raise the miss flag
    a_miss_quiet: assert property (@(posedge clk) disable iff (!rstn)
        sel_miss |-> rd_data == RESET_VAL && trap_class == 6'h00)
        else $error("foreign encoding carried payload");

    // Field by field against the package codes
    a_hash3_field: assert property (@(posedge clk) disable iff (!rstn)
        rd_valid |-> rd_data[HASH3_LSB +: FLD_W] == (st_q.cipher_on ? HASH3_ON : FLD_OFF))
        else $error("hash field wrong");

    a_rdmac_field: assert property (@(posedge clk) disable iff (!rstn)
        rd_valid |-> rd_data[RDMAC_LSB +: FLD_W] == RDMAC_CODE)
        else $error("multiply-accumulate field wrong");

    a_atomic_field: assert property (@(posedge clk) disable iff (!rstn)
        rd_valid |-> rd_data[ATOM_LSB +: FLD_W] == ATOM_CODE)
        else $error("atomic field wrong");

    a_crc_fixed: assert property (@(posedge clk) disable iff (!rstn)
        rd_valid |-> rd_data[CRC_LSB +: FLD_W] == CRC_CODE)
        else $error("checksum field wrong");

    a_sha2_field: assert property (@(posedge clk) disable iff (!rstn)
        rd_valid |-> rd_data[SHA2_LSB +: FLD_W] == (st_q.cipher_on ? SHA2_ON : FLD_OFF))
        else $error("wide hash field wrong");

    a_sha1_field: assert property (@(posedge clk) disable iff (!rstn)
        rd_valid |-> rd_data[SHA1_LSB +: FLD_W] == (st_q.cipher_on ? SHA1_ON : FLD_OFF))
        else $error("narrow hash field wrong");

    a_aes_field: assert property (@(posedge clk) disable iff (!rstn)
        rd_valid |-> rd_data[AES_LSB +: FLD_W] == (st_q.cipher_on ? AES_ON : FLD_OFF))
        else $error("block cipher field wrong");
endmodule

// [isafid_pipe.sv]
// Pipeline-side model: issues system-register reads with their privilege and trap controls.
// Assumes the bench calls put once per cycle, just after the falling clock edge.
`timescale 1ns/1ns
module isafid_pipe
    import isafid_pkg::*;
(
    output logic       rd_req,
    output logic [1:0] rd_op0,
    output logic [2:0] rd_op1,
    output logic [3:0] rd_crn,
    output logic [3:0] rd_crm,
    output logic [2:0] rd_op2,
    output logic [1:0] current_priv_level,
    output logic       hyp_level_active,
    output logic       hyp_trap_general_ctl,
    output logic       hyp_trap_id_group3_ctl
);
    task automatic put(bit r, bit hit, logic [1:0] lvl, logic [2:0] ctl);
        rd_req = r;
        {rd_op0, rd_op1, rd_crn, rd_crm, rd_op2} = {ENC_OP0, ENC_OP1, ENC_CRN, ENC_CRM, ENC_OP2};
        if (!hit) begin
            rd_op2 = 3'($urandom_range(1, 7));
        end
        // Idle cycles carry junk, as a real pipeline would
        if (!r) begin
            {rd_op0, rd_op1, rd_crn, rd_crm, rd_op2} = 16'($urandom);
        end
        current_priv_level = lvl;
        {hyp_level_active, hyp_trap_general_ctl, hyp_trap_id_group3_ctl} = ctl;
    endtask
    initial put(1'b0, 1'b1, 2'h0, 3'h0);
endmodule

// [tb_isa_feature_id_lower_fields.sv]
// Self-checking bench: random back-to-back reads against an integer model of value and traps.
// Assumes answers one enabled cycle after the request and a strap sampled at the first enabled edge.
`timescale 1ns/1ns
module tb_isa_feature_id_lower_fields;
    import isafid_pkg::*;
    logic        clk, rstn, ce, off_in, rd_req, ha, tg, id3, rv, tv, sm;
    logic [1:0]  op0, lvl, tl;
    logic [2:0]  op1, op2;
    logic [3:0]  crn, crm;
    logic [5:0]  tc;
    logic [63:0] rd, rd_b;
    int          miscompares, compares, cycles, ek, el;
    bit          on_e;
    isafid_pipe i_isafid_pipe (.rd_req(rd_req), .rd_op0(op0), .rd_op1(op1), .rd_crn(crn), .rd_crm(crm),
        .rd_op2(op2), .current_priv_level(lvl), .hyp_level_active(ha), .hyp_trap_general_ctl(tg),
        .hyp_trap_id_group3_ctl(id3));
    isafid_top i_isafid_top (.clk(clk), .rstn(rstn), .ce(ce), .cipher_option_off_in(off_in), .rd_req(rd_req),
        .rd_op0(op0), .rd_op1(op1), .rd_crn(crn), .rd_crm(crm), .rd_op2(op2), .current_priv_level(lvl),
        .hyp_level_active(ha), .hyp_trap_general_ctl(tg), .hyp_trap_id_group3_ctl(id3), .rd_valid(rv),
        .rd_data(rd), .trap_valid(tv), .trap_level(tl), .trap_class(tc), .sel_miss(sm));
    // Build without the cipher option, fed the same requests
    isafid_top #(.cipher_option_param(1'b0)) i_isafid_top_off (.clk(clk), .rstn(rstn), .ce(ce),
        .cipher_option_off_in(off_in), .rd_req(rd_req), .rd_op0(op0), .rd_op1(op1), .rd_crn(crn),
        .rd_crm(crm), .rd_op2(op2), .current_priv_level(lvl), .hyp_level_active(ha),
        .hyp_trap_general_ctl(tg), .hyp_trap_id_group3_ctl(id3), .rd_valid(), .rd_data(rd_b),
        .trap_valid(), .trap_level(), .trap_class(), .sel_miss());
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    function automatic logic [63:0] word(bit on);
        longint v = (64'(1) << 28) | (64'(2) << 20) | (64'(1) << 16);
        if (on) v |= (64'(1) << 32) | (64'(2) << 12) | (64'(1) << 8) | (64'(2) << 4);
        return 64'(v);
    endfunction
    function automatic int trap_to(int l, bit a, bit g, bit i3);
        if (l == 0) return (a && g) ? 2 : 1;
        if (l == 1 && a && i3) return 2;
        return 0;
    endfunction
    task automatic cmp_bit(logic g, logic e, string m);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %0t %s got %b", $time, m, g);
        end
    endtask
    task automatic cmp_word(logic [63:0] g, logic [63:0] e, string m);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic wrap_up();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Check the answer to the previous enabled cycle, then issue the next request
    task automatic step(bit dce, bit r, bit hit);
        logic [1:0] l;
        logic [2:0] c;
        @(negedge clk);
        cmp_bit(rv, ek == 1, "read valid");
        cmp_bit(tv, ek == 2, "trap valid");
        cmp_bit(sm, ek == 3, "select miss");
        cmp_word(rd, (ek == 1) ? word(on_e) : 64'h0, "read data");
        cmp_word(rd_b, (ek == 1) ? word(1'b0) : 64'h0, "data without option");
        cmp_word(64'(tl), (ek == 2) ? 64'(el) : 64'h0, "trap level");
        cmp_word(64'(tc), (ek == 2) ? 64'h18 : 64'h0, "trap class");
        l = 2'($urandom);
        c = 3'($urandom);
        ce = dce;
        off_in = 1'($urandom);
        i_isafid_pipe.put(r, hit, l, c);
        if (dce) begin
            el = trap_to(int'(l), c[2], c[1], c[0]);
            ek = !r ? 0 : (!hit ? 3 : (el != 0 ? 2 : 1));
        end
    endtask
    task automatic do_reset(bit strap);
        rstn = 1'b0;
        // A frozen clock enable would push the strap edge past the next random strap value
        ce = 1'b1;
        off_in = strap;
        ek = 0;
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        on_e = !strap;
        i_isafid_pipe.put(1'b1, 1'b1, 2'h2, 3'h0);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            miscompares++;
            $display("[FAIL] %0t timeout", $time);
            wrap_up();
        end
    end
    initial begin
        ce = 1'b1;
        void'($urandom(32'h5878e705));
        for (int s = 0; s < 2; s++) begin
            do_reset(1'(s));
            repeat (150) step($urandom_range(0, 7) != 0, $urandom_range(0, 3) != 0, $urandom_range(0, 4) != 0);
        end
        step(1'b1, 1'b0, 1'b1);
        wrap_up();
    end
endmodule
